// [core/akr_pkg.sv]
package akr_pkg;

  // register offsets on the management port
  localparam logic [15:0] AKR_ADR_ADV_MIDDLE = 16'h0203;
  localparam logic [15:0] AKR_ADR_ADV_HIGH = 16'h0204;
  localparam logic [15:0] AKR_ADR_PARTNER_LOW = 16'h0205;
  localparam logic [15:0] AKR_ADR_PARTNER_MIDDLE = 16'h0206;
  localparam logic [15:0] AKR_ADR_PARTNER_HIGH = 16'h0207;
  localparam logic [4:0] AKR_DEVICE_ADDR = 5'h07;

  // reset values and masks of implemented bits
  localparam logic [15:0] AKR_ADV_MIDDLE_RST = 16'h4000;
  localparam logic [15:0] AKR_ADV_HIGH_RST = 16'h0000;
  localparam logic [15:0] AKR_ADV_MIDDLE_MASK = 16'h4010;
  localparam logic [15:0] AKR_ADV_HIGH_MASK = 16'h3000;
  localparam logic [15:0] AKR_PARTNER_LOW_MASK = 16'hFC1F;
  localparam logic [15:0] AKR_PARTNER_MIDDLE_MASK = 16'h40F0;
  localparam logic [15:0] AKR_PARTNER_HIGH_MASK = 16'h7000;

  // field positions
  localparam int AKR_BIT_LONG_REACH = 14;
  localparam int AKR_BIT_ROLE_MASTER = 4;
  localparam int AKR_BIT_HIGH_ABLE = 13;
  localparam int AKR_BIT_HIGH_REQUEST = 12;
  localparam int AKR_HDR_ST = 12;
  localparam int AKR_HDR_OP_HI = 11;
  localparam int AKR_HDR_OP_LO = 10;
  localparam int AKR_HDR_PORT_HI = 9;
  localparam int AKR_HDR_PORT_LO = 5;
  localparam int AKR_HDR_DEV_HI = 4;
  localparam int AKR_HDR_DEV_LO = 0;

  // management frame timing, in sampled clock bits
  localparam logic [5:0] AKR_PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] AKR_HDR_LAST = 5'h0C;
  localparam logic [4:0] AKR_DATA_LAST = 5'h0F;
  localparam logic [4:0] AKR_TA_LAST = 5'h01;

  // frame operation codes
  localparam logic [1:0] AKR_OP_ADDRESS = 2'h0;
  localparam logic [1:0] AKR_OP_WRITE = 2'h1;
  localparam logic [1:0] AKR_OP_READ_INC = 2'h2;
  localparam logic [1:0] AKR_OP_READ = 2'h3;

  // received base page from the link partner
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] middle;
    logic [15:0] low;
  } akr_page_t;

  // management serial pins as seen by the device
  typedef struct packed {
    logic mdio_out;
    logic mdio_oe;
  } akr_mdio_drive_t;

  // frame engine states
  typedef enum logic [3:0] {
    AKR_MS_PREAMBLE = 4'b0001,
    AKR_MS_HEADER = 4'b0010,
    AKR_MS_TURN = 4'b0100,
    AKR_MS_DATA = 4'b1000
  } akr_mstate_t;

endpackage

// [core/akr_edge.sv]
`timescale 1ns/10ps
module akr_edge
  import akr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic level_in,
  output logic rise
);

  typedef struct packed {
    logic prev;
  } akr_edge_state_t;

  akr_edge_state_t st_reg;
  akr_edge_state_t st_next;

  // remember last level
  always_comb begin
    st_next = st_reg;
    st_next.prev = level_in;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // rising edge of the management clock
  assign rise = level_in & ~st_reg.prev;

endmodule

// [core/akr_tx_level.sv]
`timescale 1ns/10ps
module akr_tx_level
  import akr_pkg::*;
(
  input wire logic local_able,
  input wire logic local_request,
  input wire logic partner_able,
  input wire logic partner_request,
  output logic level_high
);

  // low level unless both able and either asks for high
  always_comb begin
    if (!(local_able && partner_able)) begin
      level_high = 1'b0;
    end else begin
      level_high = local_request | partner_request;
    end
  end

endmodule

// [core/akr_ability_regs.sv]
`timescale 1ns/10ps
module akr_ability_regs
  import akr_pkg::*;
#(
  parameter logic [4:0] PORT_ADDR = 5'h00
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic strap_role_master,
  input wire logic strap_high_able,
  input wire logic strap_high_request,
  input wire logic adv_role_forced,
  input wire logic partner_page_valid,
  input wire akr_page_t partner_page,
  output logic [15:0] adv_middle_word,
  output logic [15:0] adv_high_word,
  output logic adv_role_master,
  output logic adv_role_mandatory,
  output logic tx_level_high,
  output logic [15:0] partner_base_page_middle,
  output logic [15:0] partner_base_page_high
);

  typedef struct packed {
    akr_mstate_t ms;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [12:0] hdr;
    logic [1:0] op;
    logic [15:0] shreg;
    logic [15:0] addr;
    akr_mdio_drive_t pin;
    logic [15:0] adv_middle;
    logic [15:0] adv_high;
    logic straps_done;
    akr_page_t live;
    logic [15:0] snap_middle;
    logic [15:0] snap_high;
    logic role_mandatory;
    logic tx_high;
  } akr_state_t;

  akr_state_t st_reg;
  akr_state_t st_next;
  logic mdc_rise;
  logic level_high;
  logic [12:0] hdr_new;
  logic [15:0] data_new;
  logic [15:0] rd_data;
  logic is_read;

  // management clock edge detector
  akr_edge u_edge (
    .core_clk(core_clk),
    .resetn(resetn),
    .level_in(mdc),
    .rise(mdc_rise)
  );

  // transmit level resolution from both advertisements
  akr_tx_level u_level (
    .local_able(st_reg.adv_high[AKR_BIT_HIGH_ABLE]),
    .local_request(st_reg.adv_high[AKR_BIT_HIGH_REQUEST]),
    .partner_able(st_reg.live.high[AKR_BIT_HIGH_ABLE]),
    .partner_request(st_reg.live.high[AKR_BIT_HIGH_REQUEST]),
    .level_high(level_high)
  );

  // read mux over the register map
  always_comb begin
    unique case (st_reg.addr)
      AKR_ADR_ADV_MIDDLE: rd_data = st_reg.adv_middle;
      AKR_ADR_ADV_HIGH: rd_data = st_reg.adv_high;
      AKR_ADR_PARTNER_LOW: rd_data = st_reg.live.low;
      AKR_ADR_PARTNER_MIDDLE: rd_data = st_reg.snap_middle;
      AKR_ADR_PARTNER_HIGH: rd_data = st_reg.snap_high;
      default: rd_data = 16'h0000;
    endcase
  end

  assign hdr_new = {st_reg.hdr[11:0], mdio_in};
  assign data_new = {st_reg.shreg[14:0], mdio_in};
  assign is_read = st_reg.op[1];

  // frame engine, register writes and partner page capture
  always_comb begin
    st_next = st_reg;
    st_next.role_mandatory = adv_role_forced;
    st_next.tx_high = level_high;
    // straps load the strap-dependent bits once after reset
    if (!st_reg.straps_done) begin
      st_next.straps_done = 1'b1;
      st_next.adv_middle[AKR_BIT_ROLE_MASTER] = strap_role_master;
      st_next.adv_high[AKR_BIT_HIGH_ABLE] = strap_high_able;
      st_next.adv_high[AKR_BIT_HIGH_REQUEST] = strap_high_request;
    end
    // each received base page replaces the live partner words
    if (partner_page_valid) begin
      st_next.live.low = partner_page.low & AKR_PARTNER_LOW_MASK;
      st_next.live.middle = partner_page.middle & AKR_PARTNER_MIDDLE_MASK;
      st_next.live.high = partner_page.high & AKR_PARTNER_HIGH_MASK;
    end
    if (mdc_rise) begin
      unique case (st_reg.ms)
        AKR_MS_PREAMBLE: begin
          if (mdio_in) begin
            if (st_reg.ones != AKR_PREAMBLE_ONES) begin
              st_next.ones = st_reg.ones + 6'h01;
            end
          end else if (st_reg.ones == AKR_PREAMBLE_ONES) begin
            st_next.ms = AKR_MS_HEADER; // first start bit seen
            st_next.cnt = 5'h00;
            st_next.ones = 6'h00;
          end else begin
            st_next.ones = 6'h00;
          end
        end
        AKR_MS_HEADER: begin
          st_next.hdr = hdr_new;
          st_next.cnt = st_reg.cnt + 5'h01;
          // thirteen bits: second start bit, operation, port and device
          if (st_reg.cnt == AKR_HDR_LAST) begin
            st_next.cnt = 5'h00;
            st_next.op = hdr_new[AKR_HDR_OP_HI:AKR_HDR_OP_LO];
            // only long-form frames for this port and device are served
            if (!hdr_new[AKR_HDR_ST] &&
                hdr_new[AKR_HDR_PORT_HI:AKR_HDR_PORT_LO] == PORT_ADDR &&
                hdr_new[AKR_HDR_DEV_HI:AKR_HDR_DEV_LO] == AKR_DEVICE_ADDR) begin
              st_next.ms = AKR_MS_TURN;
            end else begin
              st_next.ms = AKR_MS_PREAMBLE;
            end
          end
        end
        AKR_MS_TURN: begin
          st_next.cnt = st_reg.cnt + 5'h01;
          if (st_reg.cnt != AKR_TA_LAST) begin
            if (is_read) begin
              // load read data and drive the turnaround zero
              st_next.shreg = rd_data;
              st_next.pin.mdio_oe = 1'b1;
              st_next.pin.mdio_out = 1'b0;
              if (st_reg.addr == AKR_ADR_PARTNER_LOW) begin
                st_next.snap_middle = st_reg.live.middle;
                st_next.snap_high = st_reg.live.high;
              end
            end
          end else begin
            st_next.ms = AKR_MS_DATA;
            st_next.cnt = 5'h00;
            if (is_read) begin
              st_next.pin.mdio_out = st_reg.shreg[15];
              st_next.shreg = {st_reg.shreg[14:0], 1'b0};
            end
          end
        end
        AKR_MS_DATA: begin
          st_next.cnt = st_reg.cnt + 5'h01;
          if (is_read) begin
            st_next.pin.mdio_out = st_reg.shreg[15];
            st_next.shreg = {st_reg.shreg[14:0], 1'b0};
          end else begin
            st_next.shreg = data_new;
          end
          if (st_reg.cnt == AKR_DATA_LAST) begin
            st_next.ms = AKR_MS_PREAMBLE;
            st_next.cnt = 5'h00;
            st_next.pin.mdio_oe = 1'b0;
            st_next.pin.mdio_out = 1'b0;
            unique case (st_reg.op)
              AKR_OP_ADDRESS: st_next.addr = data_new;
              AKR_OP_WRITE: begin
                // only implemented bits take the write
                if (st_reg.addr == AKR_ADR_ADV_MIDDLE) begin
                  st_next.adv_middle = data_new & AKR_ADV_MIDDLE_MASK;
                end else if (st_reg.addr == AKR_ADR_ADV_HIGH) begin
                  st_next.adv_high = data_new & AKR_ADV_HIGH_MASK;
                end
              end
              AKR_OP_READ_INC: st_next.addr = st_reg.addr + 16'h0001;
              AKR_OP_READ: st_next.addr = st_reg.addr;
            endcase
          end
        end
        default: begin
          st_next.ms = AKR_MS_PREAMBLE;
          st_next.pin = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.ms <= AKR_MS_PREAMBLE;
      st_reg.adv_middle <= AKR_ADV_MIDDLE_RST;
      st_reg.adv_high <= AKR_ADV_HIGH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs all come from the state register
  assign mdio_out = st_reg.pin.mdio_out;
  assign mdio_oe = st_reg.pin.mdio_oe;
  assign adv_middle_word = st_reg.adv_middle;
  assign adv_high_word = st_reg.adv_high;
  assign adv_role_master = st_reg.adv_middle[AKR_BIT_ROLE_MASTER];
  assign adv_role_mandatory = st_reg.role_mandatory;
  assign tx_level_high = st_reg.tx_high;
  assign partner_base_page_middle = st_reg.snap_middle;
  assign partner_base_page_high = st_reg.snap_high;

endmodule

// [tb/akr_ability_regs_checker.sv]
`timescale 1ns/10ps
module akr_ability_regs_checker
  import akr_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic mdio_oe,
  input wire logic strap_role_master,
  input wire logic strap_high_able,
  input wire logic strap_high_request,
  input wire logic adv_role_forced,
  input wire logic partner_page_valid,
  input wire akr_page_t partner_page,
  input wire logic [15:0] adv_middle_word,
  input wire logic [15:0] adv_high_word,
  input wire logic adv_role_master,
  input wire logic adv_role_mandatory,
  input wire logic tx_level_high,
  input wire logic [15:0] partner_base_page_middle,
  input wire logic [15:0] partner_base_page_high
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [1:0] lp_hi_reg;
  logic want;
  // partner high-level flags of the latest page
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) lp_hi_reg <= 2'h0;
    else if (partner_page_valid) lp_hi_reg <= partner_page.high[13:12];
  end
  // level that the resolution should give
  assign want = adv_high_word[13] & lp_hi_reg[1] & (adv_high_word[12] | lp_hi_reg[0]);
  sequence s_release;
    $rose(resetn);
  endsequence
  sequence s_loaded;
    s_release ##1 1'b1;
  endsequence
  AST_RESET_VALUE: assert property (s_release |-> adv_middle_word == AKR_ADV_MIDDLE_RST
    && adv_high_word == AKR_ADV_HIGH_RST) else $error("bad reset value");
  AST_STRAP_LOAD: assert property (s_loaded |-> adv_middle_word[4] == strap_role_master
    && adv_high_word[13:12] == {strap_high_able, strap_high_request}) else $error("bad strap");
  AST_RESERVED_ZERO: assert property ((adv_middle_word & ~AKR_ADV_MIDDLE_MASK) == 16'h0000
    && (adv_high_word & ~AKR_ADV_HIGH_MASK) == 16'h0000) else $error("reserved set");
  AST_ROLE_MIRROR: assert property (adv_role_master == adv_middle_word[4])
    else $error("role mismatch");
  AST_MANDATORY: assert property (1'b1 |=> adv_role_mandatory == $past(adv_role_forced))
    else $error("mandatory wrong");
  AST_LEVEL: assert property (1'b1 |=> tx_level_high == $past(want))
    else $error("level wrong");
  AST_SNAP_HOLD: assert property (!$stable(partner_base_page_middle)
    || !$stable(partner_base_page_high) |-> ##[0:1] mdio_oe) else $error("snapshot moved");
  AST_SNAP_RESERVED: assert property ((partner_base_page_middle & ~AKR_PARTNER_MIDDLE_MASK)
    == 16'h0000 && (partner_base_page_high & ~AKR_PARTNER_HIGH_MASK) == 16'h0000)
    else $error("snapshot reserved set");
endmodule
bind akr_ability_regs akr_ability_regs_checker chk_i (.core_clk(core_clk), .resetn(resetn),
  .mdio_oe(mdio_oe), .strap_role_master(strap_role_master), .strap_high_able(strap_high_able),
  .strap_high_request(strap_high_request), .adv_role_forced(adv_role_forced),
  .partner_page_valid(partner_page_valid), .partner_page(partner_page),
  .adv_middle_word(adv_middle_word), .adv_high_word(adv_high_word),
  .adv_role_master(adv_role_master), .adv_role_mandatory(adv_role_mandatory),
  .tx_level_high(tx_level_high), .partner_base_page_middle(partner_base_page_middle),
  .partner_base_page_high(partner_base_page_high));

// [tb/akr_link_partner.sv]
`timescale 1ns/10ps
module akr_link_partner
  import akr_pkg::*;
(
  output logic page_valid,
  output akr_page_t page,
  input wire logic core_clk
);
  initial begin
    page_valid = 1'b0;
    page = '0;
  end
  // one-cycle page pulse, then the bus no longer shows the page
  task automatic send(input akr_page_t p);
    p.low[4:0] = 5'h01;
    page_valid = 1'b1;
    page = p;
    @(posedge core_clk);
    #1 page_valid = 1'b0;
    page = ~p;
  endtask
endmodule

// [tb/akr_ability_regs_test.sv]
`timescale 1ns/10ps
module akr_ability_regs_test;
  import akr_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, mdc = 1'b0, host_bit = 1'b1, forced = 1'b0;
  logic srm = 1'b0, sha = 1'b0, shr = 1'b0, pv, oe, mo, lvl, arm, arq;
  akr_page_t page, pg;
  logic [15:0] amw, ahw, pbm, pbh, d, rq;
  int fail_count = 0, cmp_count = 0, mid, hi, ll, lm, lh, sm, sh;
  wire logic mdio_in = oe ? mo : host_bit; // host releases to the pulled-up level
  always #10 core_clk = ~core_clk;
  akr_link_partner lp (.page_valid(pv), .page(page), .core_clk(core_clk));
  akr_ability_regs #(.PORT_ADDR(5'h05)) dut (.core_clk(core_clk), .resetn(resetn), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mo), .mdio_oe(oe), .strap_role_master(srm),
    .strap_high_able(sha), .strap_high_request(shr), .adv_role_forced(forced),
    .partner_page_valid(pv), .partner_page(page), .adv_middle_word(amw),
    .adv_high_word(ahw), .adv_role_master(arm), .adv_role_mandatory(arq), .tx_level_high(lvl),
    .partner_base_page_middle(pbm), .partner_base_page_high(pbh));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one management bit: low half drives, sample before the rise
  task automatic slot(input logic b, output logic r);
    mdc = 1'b0;
    host_bit = b;
    repeat (2) @(posedge core_clk);
    #1 r = mo;
    mdc = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic frame(input logic [1:0] op, input logic [15:0] dw, output logic [15:0] q);
    logic r;
    logic [13:0] h;
    h = {2'b00, op, 5'h05, AKR_DEVICE_ADDR};
    repeat (32) slot(1'b1, r);
    for (int i = 13; i >= 0; i--) slot(h[i], r);
    slot(1'b1, r);
    slot(op[1], r);
    for (int i = 15; i >= 0; i--) begin
      slot(op[1] | dw[i], r);
      q[i] = r;
    end
    host_bit = 1'b1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] dw);
    logic [15:0] q;
    frame(AKR_OP_ADDRESS, a, q);
    frame(AKR_OP_WRITE, dw, q);
  endtask
  // read through the port and against the model
  task automatic rdchk(input logic [15:0] a);
    logic [15:0] q;
    int e;
    frame(AKR_OP_ADDRESS, a, q);
    frame(AKR_OP_READ, 16'h0000, q);
    e = a == AKR_ADR_ADV_MIDDLE ? mid : a == AKR_ADR_ADV_HIGH ? hi : a == AKR_ADR_PARTNER_LOW
      ? ll : a == AKR_ADR_PARTNER_MIDDLE ? sm : a == AKR_ADR_PARTNER_HIGH ? sh : 0;
    if (a == AKR_ADR_PARTNER_LOW) begin
      sm = lm;
      sh = lh;
    end
    chk(q, 16'(e), "read");
  endtask
  task automatic sendp(input akr_page_t p);
    lp.send(p);
    ll = (p.low & 'hFC00) | 'h1;
    lm = p.middle & 'h40F0;
    lh = p.high & 'h7000;
  endtask
  initial begin
    #1200000;
    fail_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    void'($urandom(17837));
    {srm, sha, shr} = 3'($urandom);
    mid = 'h4000 | (srm << 4);
    hi = (sha << 13) | (shr << 12);
    repeat (10) @(posedge core_clk);
    #1 resetn = 1'b1;
    rdchk(AKR_ADR_ADV_MIDDLE);
    rdchk(AKR_ADR_ADV_HIGH);
    rdchk(AKR_ADR_PARTNER_MIDDLE);
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      forced = d[0];
      wr(AKR_ADR_ADV_MIDDLE, d);
      mid = d & 'h4010;
      chk({15'h0, arm}, 16'((mid >> 4) & 1), "role");
      chk({15'h0, arq}, {15'h0, forced}, "mandatory");
      d[13:12] = 2'(i >> 2);
      wr(AKR_ADR_ADV_HIGH, d);
      hi = d & 'h3000;
      pg = 48'({$urandom, $urandom});
      pg.high[13:12] = 2'(i);
      sendp(pg);
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0, lvl}, 16'(i[3] & i[1] & (i[2] | i[0])), "level");
      rdchk(AKR_ADR_ADV_MIDDLE);
      rdchk(AKR_ADR_ADV_HIGH);
    end
    // read with address increment, then a plain read of the next word
    frame(AKR_OP_ADDRESS, AKR_ADR_ADV_MIDDLE, rq);
    frame(AKR_OP_READ_INC, 16'h0000, rq);
    chk(rq, 16'(mid), "read inc");
    frame(AKR_OP_READ, 16'h0000, rq);
    chk(rq, 16'(hi), "after inc");
    rdchk(AKR_ADR_PARTNER_LOW);
    pg = ~pg;
    sendp(pg);
    rdchk(AKR_ADR_PARTNER_MIDDLE);
    rdchk(AKR_ADR_PARTNER_HIGH);
    chk(pbm, 16'(sm), "snapshot");
    chk(pbh, 16'(sh), "snapshot high");
    rdchk(AKR_ADR_PARTNER_LOW);
    rdchk(AKR_ADR_PARTNER_HIGH);
    wr(AKR_ADR_PARTNER_LOW, 16'hFFFF);
    wr(16'h0210, 16'hFFFF);
    rdchk(16'h0210);
    rdchk(AKR_ADR_PARTNER_LOW);
    chk(amw, 16'(mid), "middle");
    chk(ahw, 16'(hi), "high");
    print_verdict;
  end
endmodule
